// ---- design/rsx_pkg.sv ----
package rsx_pkg;

    // ------------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        RSX_OP_NONE   = 3'h0,
        RSX_OP_ROTL   = 3'h1,
        RSX_OP_ROTR   = 3'h2,
        RSX_OP_LSUB   = 3'h3,
        RSX_OP_FSUB   = 3'h4,
        RSX_OP_SWAP   = 3'h5,
        RSX_OP_SLEEP  = 3'h6
    } rsx_op_e;

    // ------------------------------------------------------------------
    // destination, widths and reset values
    // ------------------------------------------------------------------
    localparam logic       DEST_ACC     = 1'h0;
    localparam logic       DEST_FILE    = 1'h1;
    localparam int         DATA_W       = 8;
    localparam int         ADDR_W       = 7;
    localparam int         WDT_W        = 8;
    localparam int         PRE_W        = 8;
    localparam int         MSB_POS      = 7;
    localparam int         NIB_MSB_POS  = 3;
    localparam logic [7:0] WDT_CLEARED  = 8'h00;
    localparam logic [7:0] PRE_CLEARED  = 8'h00;
    localparam logic [7:0] ACC_RST      = 8'h00;
    localparam logic       TIMEOUT_RST  = 1'h1;
    localparam logic       PDOWN_RST    = 1'h1;

endpackage : rsx_pkg

// ---- design/rsx_exec.sv ----
module rsx_exec
(
    // clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_rstn,
    // instruction
    input  wire logic                       i_valid,
    input  wire rsx_pkg::rsx_op_e           i_op,
    input  wire logic                       i_dest,
    input  wire logic [rsx_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [rsx_pkg::DATA_W-1:0] i_lit,
    input  wire logic [rsx_pkg::DATA_W-1:0] i_fdata,
    // watchdog and wake-up
    input  wire logic                       i_wdt_tick,
    input  wire logic                       i_wake,
    // results
    output logic                            o_fwr,
    output logic      [rsx_pkg::ADDR_W-1:0] o_faddr,
    output logic      [rsx_pkg::DATA_W-1:0] o_fwdata,
    output logic      [rsx_pkg::DATA_W-1:0] o_acc,
    // status
    output logic                            o_carry,
    output logic                            o_half_borrow_flag,
    output logic                            o_zero,
    output logic                            o_timeout_bit,
    output logic                            o_powerdown_bit,
    output logic      [rsx_pkg::WDT_W-1:0]  o_wdt,
    output logic      [rsx_pkg::PRE_W-1:0]  o_wdt_pre,
    output logic                            o_sleep,
    output logic                            o_osc_run
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic                       fwr;
        logic [rsx_pkg::ADDR_W-1:0] faddr;
        logic [rsx_pkg::DATA_W-1:0] fwdata;
        logic [rsx_pkg::DATA_W-1:0] acc;
        logic                       c;
        logic                       half_borrow;
        logic                       z;
        logic                       to;
        logic                       powerdown;
        logic [rsx_pkg::WDT_W-1:0]  wdt;
        logic [rsx_pkg::PRE_W-1:0]  pre;
        logic                       sleep;
        logic                       osc_run;
    } rsx_state_s;

    rsx_state_s st_r;
    rsx_state_s st_nxt;

    logic [rsx_pkg::DATA_W:0]   diff;
    logic [4:0]                 ldiff;
    logic [rsx_pkg::DATA_W-1:0] minuend;
    logic [rsx_pkg::DATA_W-1:0] res;
    logic                       wr_res;

    // ------------------------------------------------------------------
    // subtract datapath
    // ------------------------------------------------------------------
    always_comb
    begin
        minuend = (i_op == rsx_pkg::RSX_OP_LSUB) ? i_lit : i_fdata;
        diff    = {1'b0, minuend} - {1'b0, st_r.acc};
        ldiff   = {1'b0, minuend[3:0]} - {1'b0, st_r.acc[3:0]};
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.fwr = 1'b0;
        res        = i_fdata;
        wr_res     = 1'b0;
        // watchdog counts on every i_wdt_tick, asleep or awake, except that a SLEEP issued that cycle clears it; wake-up restarts the oscillator
        if (i_wdt_tick)
        begin
            st_nxt.pre = st_r.pre + 8'h01;
            if (st_r.pre == {rsx_pkg::PRE_W{1'b1}})
                st_nxt.wdt = st_r.wdt + 8'h01;
        end
        if (st_r.sleep)
        begin
            if (i_wake)
                st_nxt.sleep = 1'b0;
        end
        else if (i_valid)
        begin
            case (i_op)
                rsx_pkg::RSX_OP_ROTL:
                begin
                    res    = {i_fdata[6:0], st_r.c};
                    st_nxt.c = i_fdata[rsx_pkg::MSB_POS];
                    wr_res = 1'b1;
                end
                rsx_pkg::RSX_OP_ROTR:
                begin
                    res    = {st_r.c, i_fdata[7:1]};
                    st_nxt.c = i_fdata[0];
                    wr_res = 1'b1;
                end
                rsx_pkg::RSX_OP_LSUB:
                begin
                    st_nxt.acc = diff[7:0];
                    st_nxt.c   = ~diff[rsx_pkg::DATA_W];
                    st_nxt.half_borrow = ~ldiff[4];
                    st_nxt.z   = (diff[7:0] == 8'h00);
                end
                rsx_pkg::RSX_OP_FSUB:
                begin
                    res       = diff[7:0];
                    st_nxt.c  = ~diff[rsx_pkg::DATA_W];
                    st_nxt.half_borrow = ~ldiff[4];
                    st_nxt.z  = (diff[7:0] == 8'h00);
                    wr_res    = 1'b1;
                end
                rsx_pkg::RSX_OP_SWAP:
                begin
                    res    = {i_fdata[3:0], i_fdata[7:4]};
                    wr_res = 1'b1;
                end
                rsx_pkg::RSX_OP_SLEEP:
                begin
                    st_nxt.wdt   = rsx_pkg::WDT_CLEARED;
                    st_nxt.pre   = rsx_pkg::PRE_CLEARED;
                    st_nxt.powerdown = 1'b0;
                    st_nxt.to    = 1'b1;
                    st_nxt.sleep = 1'b1;
                end
                default:
                begin
                    wr_res = 1'b0;
                end
            endcase
            // route result by destination bit
            if (wr_res)
            begin
                if (i_dest == rsx_pkg::DEST_FILE)
                begin
                    st_nxt.fwr    = 1'b1;
                    st_nxt.faddr  = i_addr;
                    st_nxt.fwdata = res;
                end
                else
                    st_nxt.acc = res;
            end
        end
        // oscillator runs whenever the core is awake
        st_nxt.osc_run = ~st_nxt.sleep;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            st_r        <= '0;
            st_r.acc    <= rsx_pkg::ACC_RST;
            st_r.to     <= rsx_pkg::TIMEOUT_RST;
            st_r.powerdown <= rsx_pkg::PDOWN_RST;
            st_r.osc_run   <= 1'b1;                 // awake out of reset
        end
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_fwr              = st_r.fwr;
    assign o_faddr            = st_r.faddr;
    assign o_fwdata           = st_r.fwdata;
    assign o_acc              = st_r.acc;
    assign o_carry            = st_r.c;
    assign o_half_borrow_flag = st_r.half_borrow;
    assign o_zero             = st_r.z;
    assign o_timeout_bit      = st_r.to;
    assign o_powerdown_bit    = st_r.powerdown;
    assign o_wdt              = st_r.wdt;
    assign o_wdt_pre          = st_r.pre;
    assign o_sleep            = st_r.sleep;
    assign o_osc_run          = st_r.osc_run;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    logic run_ok;
    assign run_ok = i_valid && !st_r.sleep;

    sequence swap_issue_s;
        run_ok && i_op == rsx_pkg::RSX_OP_SWAP;
    endsequence

    sequence sleep_issue_s;
        run_ok && i_op == rsx_pkg::RSX_OP_SLEEP;
    endsequence

    sequence asleep_req_s;
        o_sleep && i_valid;
    endsequence

    rotl_value_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        run_ok && i_op == rsx_pkg::RSX_OP_ROTL && i_dest == 1'b0 |=>
        o_acc == {$past(i_fdata[6:0]), $past(o_carry)}
        && o_carry == $past(i_fdata[7]) && $stable(o_zero))
        else $error("rotate left result wrong");

    rotr_value_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        run_ok && i_op == rsx_pkg::RSX_OP_ROTR && i_dest == 1'b0 |=>
        o_acc == {$past(o_carry), $past(i_fdata[7:1])}
        && o_carry == $past(i_fdata[0]) && $stable(o_half_borrow_flag))
        else $error("rotate right result wrong");

    dest_file_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        run_ok && i_dest && (i_op == rsx_pkg::RSX_OP_FSUB
        || i_op == rsx_pkg::RSX_OP_SWAP) |=>
        o_fwr && o_faddr == $past(i_addr) && $stable(o_acc))
        else $error("file write-back missing");

    lsub_value_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        run_ok && i_op == rsx_pkg::RSX_OP_LSUB |=>
        o_acc == 8'($past(i_lit) - $past(o_acc))
        && o_zero == (o_acc == 8'h00) && !o_fwr)
        else $error("literal subtract wrong");

    fsub_flag_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        run_ok && i_op == rsx_pkg::RSX_OP_FSUB |=>
        o_carry == ($past(i_fdata) >= $past(o_acc))
        && o_half_borrow_flag == ($past(i_fdata[3:0]) >= $past(o_acc[3:0])))
        else $error("subtract flags wrong");

    swap_value_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        swap_issue_s ##0 i_dest == 1'b0 |=>
        o_acc == {$past(i_fdata[3:0]), $past(i_fdata[7:4])})
        else $error("nibble swap wrong");

    swap_flags_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        swap_issue_s |=> $stable(o_carry) && $stable(o_zero)
        && $stable(o_half_borrow_flag))
        else $error("swap changed a flag");

    sleep_wdt_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        sleep_issue_s |=> o_wdt == 8'h00 && o_wdt_pre == 8'h00)
        else $error("watchdog not cleared");

    sleep_bits_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        sleep_issue_s |=> o_timeout_bit && !o_powerdown_bit)
        else $error("status bits wrong");

    sleep_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        sleep_issue_s ##1 !i_wake |=> o_sleep && !o_osc_run && $stable(o_acc))
        else $error("sleep not held");

    osc_sleep_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        o_osc_run == !o_sleep)
        else $error("oscillator state wrong");

    sleep_ignore_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        asleep_req_s |=> $stable(o_acc) && $stable(o_carry) && !o_fwr)
        else $error("instruction ran while asleep");

    fsub_value_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        run_ok && i_op == rsx_pkg::RSX_OP_FSUB && i_dest == 1'b0 |=>
        o_acc == 8'($past(i_fdata) - $past(o_acc))
        && o_zero == (o_acc == 8'h00) && !o_fwr)
        else $error("file subtract wrong");

    rot_file_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        run_ok && i_op == rsx_pkg::RSX_OP_ROTR && i_dest |=>
        o_fwr && o_fwdata == {$past(o_carry), $past(i_fdata[7:1])}
        && o_carry == $past(i_fdata[0]) && $stable(o_acc))
        else $error("rotate write-back wrong");

endmodule : rsx_exec

// ---- sim/rsx_exec_tb.sv ----
module rsx_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // stimulus, observed outputs and bookkeeping
    // ------------------------------------------------------------------
    logic             i_clk      = 1'h0;
    logic             i_rstn     = 1'h0;
    logic             i_valid    = 1'h0;
    rsx_pkg::rsx_op_e i_op       = rsx_pkg::RSX_OP_NONE;
    logic             i_dest     = 1'h0;
    logic [6:0]       i_addr     = 7'h2A;
    logic [7:0]       i_lit      = 8'h00;
    logic [7:0]       i_fdata    = 8'h00;
    logic             i_wdt_tick = 1'h0;
    logic             i_wake     = 1'h0;
    logic             o_fwr, o_carry, o_half_borrow_flag, o_zero;
    logic             o_timeout_bit, o_powerdown_bit, o_sleep, o_osc_run;
    logic [6:0]       o_faddr;
    logic [7:0]       o_fwdata, o_acc, o_wdt, o_wdt_pre;
    int               n_errors    = 0;
    int               checks_done = 0;
    logic [7:0]       acc_exp     = 8'h00;

    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;

    rsx_exec dut
    (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_valid(i_valid), .i_op(i_op),
        .i_dest(i_dest), .i_addr(i_addr), .i_lit(i_lit),
        .i_fdata(i_fdata), .i_wdt_tick(i_wdt_tick), .i_wake(i_wake),
        .o_fwr(o_fwr), .o_faddr(o_faddr), .o_fwdata(o_fwdata),
        .o_acc(o_acc), .o_carry(o_carry),
        .o_half_borrow_flag(o_half_borrow_flag), .o_zero(o_zero),
        .o_timeout_bit(o_timeout_bit), .o_powerdown_bit(o_powerdown_bit),
        .o_wdt(o_wdt), .o_wdt_pre(o_wdt_pre), .o_sleep(o_sleep),
        .o_osc_run(o_osc_run)
    );

    // ------------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one instruction, sampled just after the edge that registers it
    task automatic issue(input rsx_pkg::rsx_op_e op, input logic d,
                         input logic [7:0] lit, input logic [7:0] fd);
        @(posedge i_clk);
        i_valid <= 1'h1;
        i_op    <= op;
        i_dest  <= d;
        i_lit   <= lit;
        i_fdata <= fd;
        @(posedge i_clk);
        i_valid <= 1'h0;
        i_op    <= rsx_pkg::RSX_OP_NONE;
        #1;
    endtask : issue

    // result lands in accumulator or file write, never both
    task automatic res(input logic d, input logic [7:0] v);
        chk("fwr", o_fwr, d);
        if (d)
        begin
            chk("faddr", o_faddr, 7'h2A);
            chk("fwdata", o_fwdata, v);
        end
        else
            acc_exp = v;
        chk("acc", o_acc, acc_exp);
    endtask : res

    task automatic flags(input logic c, input logic dc, input logic z);
        chk("carry", o_carry, c);
        chk("half_borrow", o_half_borrow_flag, dc);
        chk("zero", o_zero, z);
    endtask : flags

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        res(1'h0, 8'h00);
        flags(1'h0, 1'h0, 1'h0);
        chk("to", o_timeout_bit, 1'h1);
        chk("pd", o_powerdown_bit, 1'h1);
        chk("sleep", o_sleep, 1'h0);
        chk("osc", o_osc_run, 1'h1);
        chk("wdt", o_wdt, 8'h00);
        chk("wdt_pre", o_wdt_pre, 8'h00);
    endtask : t_reset

    task automatic t_sub;
        issue(rsx_pkg::RSX_OP_LSUB, 1'h0, 8'h10, 8'hEE);
        res(1'h0, 8'h10);
        flags(1'h1, 1'h1, 1'h0);
        issue(rsx_pkg::RSX_OP_LSUB, 1'h0, 8'h10, 8'hEE);
        res(1'h0, 8'h00);
        flags(1'h1, 1'h1, 1'h1);
        issue(rsx_pkg::RSX_OP_LSUB, 1'h0, 8'h05, 8'hEE);
        res(1'h0, 8'h05);
        issue(rsx_pkg::RSX_OP_FSUB, 1'h1, 8'hEE, 8'h03);
        res(1'h1, 8'hFE);
        flags(1'h0, 1'h0, 1'h0);
        issue(rsx_pkg::RSX_OP_FSUB, 1'h0, 8'hEE, 8'h14);
        res(1'h0, 8'h0F);
        flags(1'h1, 1'h0, 1'h0);
    endtask : t_sub

    // carry enters at 1 here; half borrow and zero must not move
    task automatic t_rot;
        issue(rsx_pkg::RSX_OP_ROTL, 1'h0, 8'h00, 8'h81);
        res(1'h0, 8'h03);
        flags(1'h1, 1'h0, 1'h0);
        issue(rsx_pkg::RSX_OP_ROTL, 1'h1, 8'h00, 8'h40);
        res(1'h1, 8'h81);
        flags(1'h0, 1'h0, 1'h0);
        issue(rsx_pkg::RSX_OP_ROTR, 1'h0, 8'h00, 8'h01);
        res(1'h0, 8'h00);
        flags(1'h1, 1'h0, 1'h0);
        issue(rsx_pkg::RSX_OP_ROTR, 1'h1, 8'h00, 8'h02);
        res(1'h1, 8'h81);
        flags(1'h0, 1'h0, 1'h0);
    endtask : t_rot

    task automatic t_swap;
        issue(rsx_pkg::RSX_OP_LSUB, 1'h0, 8'h00, 8'h00);
        res(1'h0, 8'h00);
        issue(rsx_pkg::RSX_OP_SWAP, 1'h0, 8'h00, 8'hA5);
        res(1'h0, 8'h5A);
        flags(1'h1, 1'h1, 1'h1);
        issue(rsx_pkg::RSX_OP_SWAP, 1'h1, 8'h00, 8'h3C);
        res(1'h1, 8'hC3);
        flags(1'h1, 1'h1, 1'h1);
        // empty operation must neither write nor move the accumulator
        issue(rsx_pkg::RSX_OP_NONE, 1'h1, 8'h00, 8'h99);
        chk("fwr", o_fwr, 1'h0);
        chk("acc", o_acc, acc_exp);
    endtask : t_swap

    task automatic t_sleep;
        @(posedge i_clk);
        i_wdt_tick <= 1'h1;
        // prescaler wraps once, so both counters hold something to clear
        repeat (260) @(posedge i_clk);
        i_wdt_tick <= 1'h0;
        #1;
        chk("wdt", o_wdt, 8'h01);
        chk("wdt_pre", o_wdt_pre, 8'h04);
        chk("pd", o_powerdown_bit, 1'h1);
        issue(rsx_pkg::RSX_OP_SLEEP, 1'h0, 8'h00, 8'h00);
        chk("wdt", o_wdt, 8'h00);
        chk("wdt_pre", o_wdt_pre, 8'h00);
        chk("to", o_timeout_bit, 1'h1);
        chk("pd", o_powerdown_bit, 1'h0);
        chk("sleep", o_sleep, 1'h1);
        chk("osc", o_osc_run, 1'h0);
        issue(rsx_pkg::RSX_OP_LSUB, 1'h0, 8'h77, 8'h00);
        chk("acc", o_acc, acc_exp);
        chk("sleep", o_sleep, 1'h1);
        @(posedge i_clk);
        i_wake <= 1'h1;
        @(posedge i_clk);
        i_wake <= 1'h0;
        #1;
        chk("sleep", o_sleep, 1'h0);
        chk("osc", o_osc_run, 1'h1);
        issue(rsx_pkg::RSX_OP_SWAP, 1'h0, 8'h00, 8'h12);
        res(1'h0, 8'h21);
    endtask : t_sleep

    // ------------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // hang guard, far beyond the few hundred cycles needed
    initial
    begin
        #5000;
        n_errors++;
        conclude();
    end

    initial
    begin
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'h1;
        #1;
        t_reset();
        t_sub();
        t_rot();
        t_swap();
        t_sleep();
        // second reset in mid-run brings the status bits back
        @(posedge i_clk);
        i_rstn <= 1'h0;
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'h1;
        #1;
        t_reset();
        conclude();
    end

endmodule : rsx_exec_tb
